// [shared/uct_pkg.sv]
// Constants shared by the serial transmitter block
package uct_pkg;
  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CSA = 8'h00;
  localparam logic [7:0] OFS_CSB = 8'h04;
  localparam logic [7:0] OFS_CSC = 8'h08;
  localparam logic [7:0] OFS_DIVL = 8'h0C;
  localparam logic [7:0] OFS_DIVH = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register identifiers used by the decoder
  localparam logic [2:0] ID_A = 3'h0;
  localparam logic [2:0] ID_B = 3'h1;
  localparam logic [2:0] ID_C = 3'h2;
  localparam logic [2:0] ID_DL = 3'h3;
  localparam logic [2:0] ID_DH = 3'h4;
  localparam logic [2:0] ID_DATA = 3'h5;
  localparam logic [2:0] ID_NONE = 3'h7;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int A_DBL = 0;
  localparam int A_FE = 4;
  localparam int A_BE = 5;
  localparam int A_TXD = 6;
  localparam int A_RXD = 7;
  localparam int B_TXB8 = 0;
  localparam int B_RXB8 = 1;
  localparam int B_CS2 = 2;
  localparam int B_TRANSMIT_ENABLE_BIT = 3;
  localparam int B_RXEN = 4;
  localparam int C_POL = 0;
  localparam int C_CS = 1;
  localparam int C_STOP = 3;
  localparam int C_PAR = 4;
  localparam int C_SYNC = 6;
  localparam int C_MSTR = 7;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] CSC_RST = 8'h06;
  localparam logic [11:0] DIV_RST = 12'h000;
  localparam logic [3:0] PRE_NORM_LAST = 4'hF;
  localparam logic [3:0] PRE_DBL_LAST = 4'h7;
  localparam logic [3:0] HALF_NORM = 4'h8;
  localparam logic [3:0] HALF_DBL = 4'h4;
  localparam logic [3:0] LEN_9 = 4'h9;
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_5 = 4'h5;
  localparam int FRAME_W = 13;
endpackage

// [logic/uct_usart.sv]
// Serial transmitter with baud generator, clock sync, framing and receive stop check
// Function
// - Baud divisor is twelve bits split over high and low registers.
// - Down-counter reloads divisor at zero or on low-byte write; ticks at zero.
// - Transmit bit rate is baud tick over 16, 8, or 2 in sync master.
// - Double speed shortens asynchronous bit period from 16 to 8 ticks.
// - Asynchronous receiver takes one mid-bit sample per 8 ticks in double speed, otherwise per 16.
// - Double speed is ignored in synchronous mode; software keeps it clear.
// - Slave transfer clock passes a synchroniser and edge detector first.
// - Transfer clock pin is output as sync master with transmit or receive enabled, otherwise input.
// - Sync data is sampled on the edge opposite the change edge.
// - Polarity clear: change on rising, sample falling; set: the reverse.
// - All thirty frame formats are supported.
// - Frame order: start, data LSB first, optional parity, stop bits.
// - After a frame the line starts the next frame or idles high.
// - Format settings are shared; changing them aborts traffic both ways.
// - Receiver checks only the first stop bit for frame error.
// - Parity is XOR of data bits, inverted for odd parity.
// - Transmit enable takes over the serial output pin.
// - Sync master transmit with enable drives the transfer clock pin.
// - Data register write loads the buffer and starts sending.
// - Buffer moves to shifter when idle or right after last stop bit.
// - Unused upper data bits are ignored for short characters.
// - Buffer-empty flag shows no pending data; a data write clears it.
// - Transmit-done sets when frame ends with empty buffer; write one clears.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module uct_usart #(
  parameter int ADDR_W = uct_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Serial pins
  input wire logic serial_in_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_n_out,
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe_n_out
);
  // ****************************************
  // State
  // ****************************************
  localparam int FRAME_W_L = uct_pkg::FRAME_W;
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [11:0] baud_divisor;
    logic [11:0] baud_cnt;
    logic dbl;
    logic transmit_enable_bit;
    logic rxen;
    logic cs2;
    logic txb8;
    logic [7:0] ctrl_c;
    logic [8:0] tx_buf;
    logic buf_full;
    logic shifting;
    logic [FRAME_W_L-1:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_pre;
    logic tx_line;
    logic tx_oe_n;
    logic tx_done;
    logic xck_o;
    logic xck_oe_n;
    logic [2:0] xck_s;
    logic [1:0] rxd_s;
    logic rx_busy;
    logic [3:0] rx_ph;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic [8:0] rx_data;
    logic rx_done;
    logic fe;
  } uct_st_t;
  localparam uct_st_t ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, tx_line: 1'b1,
    tx_oe_n: 1'b1, xck_oe_n: 1'b1, ctrl_c: uct_pkg::CSC_RST, baud_divisor: uct_pkg::DIV_RST,
    baud_cnt: uct_pkg::DIV_RST, default: '0};

  uct_st_t s;
  uct_st_t n;
  logic wr, rd, wen, dl_wr, data_wr, data_rd, fmt_chg, set_txd, set_rxd, load;
  logic [2:0] wid, rid, cs;
  logic [3:0] nbits, flen, pre_last, half, stop_idx;
  logic par_en, par_odd, sync, mstr, pol, btick, a_tick, tx_tick, line;
  logic chg, samp, rsamp, par;
  logic [8:0] dm;
  logic [FRAME_W_L-1:0] frame;

  // Address decode shared by reads and writes
  function automatic logic [2:0] reg_id(input logic [ADDR_W-1:0] a);
    case (a)
      uct_pkg::OFS_CSA: reg_id = uct_pkg::ID_A;
      uct_pkg::OFS_CSB: reg_id = uct_pkg::ID_B;
      uct_pkg::OFS_CSC: reg_id = uct_pkg::ID_C;
      uct_pkg::OFS_DIVL: reg_id = uct_pkg::ID_DL;
      uct_pkg::OFS_DIVH: reg_id = uct_pkg::ID_DH;
      uct_pkg::OFS_DATA: reg_id = uct_pkg::ID_DATA;
      default: reg_id = uct_pkg::ID_NONE;
    endcase
  endfunction

  // Character size code to data bit count, shared by both directions
  function automatic logic [3:0] data_len(input logic [2:0] c);
    if (c == 3'h7) begin
      data_len = uct_pkg::LEN_9;
    end else if (c[2]) begin
      data_len = uct_pkg::LEN_8;
    end else begin
      data_len = uct_pkg::LEN_5 + {2'h0, c[1:0]};
    end
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    n = s;
    set_txd = 1'b0;
    set_rxd = 1'b0;
    load = 1'b0;
    rsamp = 1'b0;
    // Format decode, one setting for both directions
    cs = {s.cs2, s.ctrl_c[uct_pkg::C_CS+1:uct_pkg::C_CS]};
    nbits = data_len(cs);
    par_en = s.ctrl_c[uct_pkg::C_PAR+1];
    par_odd = s.ctrl_c[uct_pkg::C_PAR];
    sync = s.ctrl_c[uct_pkg::C_SYNC];
    mstr = s.ctrl_c[uct_pkg::C_MSTR];
    pol = s.ctrl_c[uct_pkg::C_POL];
    stop_idx = nbits + {3'h0, par_en} + 4'h1;
    // Write address and data are taken in either order
    if (s.awready && s_axi_awvalid_in) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr_in;
    end
    if (s.wready && s_axi_wvalid_in) begin
      n.w_held = 1'b1;
      n.wdata = s_axi_wdata_in[7:0];
      n.wstb = s_axi_wstrb_in[0];
    end
    if (s.bvalid && s_axi_bready_in) begin
      n.bvalid = 1'b0;
    end
    wr = s.aw_held && s.w_held && !s.bvalid;
    wid = reg_id(s.aw_addr);
    if (wr) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (wid == uct_pkg::ID_NONE) ? uct_pkg::RESP_SLVERR : uct_pkg::RESP_OK;
    end
    wen = wr && s.wstb;
    dl_wr = wen && (wid == uct_pkg::ID_DL);
    data_wr = wen && (wid == uct_pkg::ID_DATA);
    fmt_chg = wen && (((wid == uct_pkg::ID_C) && (s.wdata != s.ctrl_c))
      || ((wid == uct_pkg::ID_B) && (s.wdata[uct_pkg::B_CS2] != s.cs2)));
    // Register stores
    if (wen) begin
      case (wid)
        uct_pkg::ID_A: begin
          n.dbl = s.wdata[uct_pkg::A_DBL];
        end
        uct_pkg::ID_B: begin
          n.txb8 = s.wdata[uct_pkg::B_TXB8];
          n.cs2 = s.wdata[uct_pkg::B_CS2];
          n.transmit_enable_bit = s.wdata[uct_pkg::B_TRANSMIT_ENABLE_BIT];
          n.rxen = s.wdata[uct_pkg::B_RXEN];
        end
        uct_pkg::ID_C: begin
          n.ctrl_c = s.wdata;
        end
        uct_pkg::ID_DL: begin
          n.baud_divisor[7:0] = s.wdata;
        end
        uct_pkg::ID_DH: begin
          n.baud_divisor[11:8] = s.wdata[3:0];
        end
        default: begin
        end
      endcase
    end
    // Read channel, answer one cycle after address
    if (s.rvalid && s_axi_rready_in) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    rd = s.arready && s_axi_arvalid_in;
    rid = reg_id(s_axi_araddr_in);
    data_rd = rd && (rid == uct_pkg::ID_DATA);
    if (rd) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = (rid == uct_pkg::ID_NONE) ? uct_pkg::RESP_SLVERR : uct_pkg::RESP_OK;
      n.rdata = 8'h00;
      case (rid)
        uct_pkg::ID_A: begin
          n.rdata[uct_pkg::A_DBL] = s.dbl;
          n.rdata[uct_pkg::A_FE] = s.fe;
          n.rdata[uct_pkg::A_BE] = !s.buf_full;
          n.rdata[uct_pkg::A_TXD] = s.tx_done;
          n.rdata[uct_pkg::A_RXD] = s.rx_done;
        end
        uct_pkg::ID_B: begin
          n.rdata[uct_pkg::B_TXB8] = s.txb8;
          n.rdata[uct_pkg::B_RXB8] = s.rx_data[8];
          n.rdata[uct_pkg::B_CS2] = s.cs2;
          n.rdata[uct_pkg::B_TRANSMIT_ENABLE_BIT] = s.transmit_enable_bit;
          n.rdata[uct_pkg::B_RXEN] = s.rxen;
        end
        uct_pkg::ID_C: n.rdata = s.ctrl_c;
        uct_pkg::ID_DL: n.rdata = s.baud_divisor[7:0];
        uct_pkg::ID_DH: n.rdata = {4'h0, s.baud_divisor[11:8]};
        uct_pkg::ID_DATA: n.rdata = s.rx_data[7:0];
        default: n.rdata = 8'h00;
      endcase
    end
    // Baud generator down-counter
    btick = (s.baud_cnt == 12'h000);
    if (btick || dl_wr) begin
      n.baud_cnt = n.baud_divisor;
    end else begin
      n.baud_cnt = s.baud_cnt - 12'h001;
    end
    // Pin synchronisers and slave clock edge detect
    n.xck_s = {s.xck_s[1:0], transfer_clock_pin_in};
    n.rxd_s = {s.rxd_s[0], serial_in_pin_in};
    line = s.rxd_s[1];
    // Master clock toggles each baud tick, halving it
    if (sync && mstr && btick) begin
      n.xck_o = !s.xck_o;
    end
    if (mstr) begin
      chg = btick && (s.xck_o == pol);
      samp = btick && (s.xck_o != pol);
    end else begin
      chg = pol ? (!s.xck_s[1] && s.xck_s[2]) : (s.xck_s[1] && !s.xck_s[2]);
      samp = pol ? (s.xck_s[1] && !s.xck_s[2]) : (!s.xck_s[1] && s.xck_s[2]);
    end
    n.xck_oe_n = !(sync && mstr && (n.transmit_enable_bit || n.rxen));
    // Asynchronous bit prescaler
    pre_last = s.dbl ? uct_pkg::PRE_DBL_LAST : uct_pkg::PRE_NORM_LAST;
    half = s.dbl ? uct_pkg::HALF_DBL : uct_pkg::HALF_NORM;
    a_tick = btick && (s.tx_pre >= pre_last);
    if (btick) begin
      n.tx_pre = a_tick ? 4'h0 : s.tx_pre + 4'h1;
    end
    tx_tick = sync ? chg : a_tick;
    // Frame build from buffer with unused bits masked
    for (int i = 0; i < 9; i++) begin
      dm[i] = s.tx_buf[i] && (4'(i) < nbits);
    end
    par = (^dm) ^ par_odd;
    frame = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nbits) begin
        frame[i+1] = dm[i];
      end
    end
    if (par_en) begin
      frame[nbits+4'h1] = par;
    end
    flen = stop_idx + {3'h0, s.ctrl_c[uct_pkg::C_STOP]} + 4'h1;
    // Shifter sequencing, one bit per tick
    if (tx_tick) begin
      if (s.shifting && (s.tx_left != 4'h0)) begin
        n.tx_line = s.tx_sh[0];
        n.tx_sh = {1'b1, s.tx_sh[FRAME_W_L-1:1]};
        n.tx_left = s.tx_left - 4'h1;
      end else if (s.buf_full && (s.transmit_enable_bit || !s.tx_oe_n)) begin
        load = 1'b1;
      end else if (s.shifting) begin
        n.shifting = 1'b0;
        n.tx_line = 1'b1;
        set_txd = 1'b1;
      end
    end
    if (load) begin
      n.tx_line = frame[0];
      n.tx_sh = {1'b1, frame[FRAME_W_L-1:1]};
      n.tx_left = flen - 4'h1;
      n.shifting = 1'b1;
      n.buf_full = 1'b0;
    end
    // Receiver sampling
    if (!s.rxen) begin
      n.rx_busy = 1'b0;
    end else if (!sync) begin
      if (btick) begin
        if (!s.rx_busy) begin
          if (!line) begin
            n.rx_busy = 1'b1;
            n.rx_ph = 4'h0;
            n.rx_bit = 4'h0;
            n.rx_sh = 9'h000;
          end
        end else begin
          n.rx_ph = (s.rx_ph >= pre_last) ? 4'h0 : s.rx_ph + 4'h1;
          rsamp = (n.rx_ph == half);
        end
      end
    end else if (samp) begin
      if (!s.rx_busy) begin
        if (!line) begin
          n.rx_busy = 1'b1;
          n.rx_bit = 4'h1;
          n.rx_sh = 9'h000;
        end
      end else begin
        rsamp = 1'b1;
      end
    end
    if (rsamp) begin
      n.rx_bit = s.rx_bit + 4'h1;
      if (s.rx_bit == 4'h0) begin
        n.rx_busy = !line;
      end else if (s.rx_bit <= nbits) begin
        n.rx_sh[s.rx_bit-4'h1] = line;
      end else if (s.rx_bit == stop_idx) begin
        n.rx_busy = 1'b0;
        n.rx_data = s.rx_sh;
        set_rxd = 1'b1;
      end
    end
    // Format change aborts both directions
    if (fmt_chg) begin
      n.shifting = 1'b0;
      n.tx_line = 1'b1;
      n.rx_busy = 1'b0;
    end
    // Buffer write wins over the move to the shifter
    if (data_wr) begin
      n.tx_buf = {n.txb8, s.wdata};
      n.buf_full = 1'b1;
    end
    n.tx_oe_n = !(n.transmit_enable_bit || n.shifting || n.buf_full);
    // Flags, set wins over clear
    if (wen && (wid == uct_pkg::ID_A) && s.wdata[uct_pkg::A_TXD]) begin
      n.tx_done = 1'b0;
    end
    if (set_txd) begin
      n.tx_done = 1'b1;
    end
    if (data_rd) begin
      n.rx_done = 1'b0;
      n.fe = 1'b0;
    end
    if (set_rxd) begin
      n.rx_done = 1'b1;
      n.fe = !line;
    end
    // Bus ready flags follow the held state
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from state
  assign s_axi_awready_out = s.awready;
  assign s_axi_wready_out = s.wready;
  assign s_axi_bresp_out = s.bresp;
  assign s_axi_bvalid_out = s.bvalid;
  assign s_axi_arready_out = s.arready;
  assign s_axi_rdata_out = {24'h000000, s.rdata};
  assign s_axi_rresp_out = s.rresp;
  assign s_axi_rvalid_out = s.rvalid;
  assign serial_out_pin_out = s.tx_line;
  assign serial_out_pin_oe_n_out = s.tx_oe_n;
  assign transfer_clock_pin_out = s.xck_o;
  assign transfer_clock_pin_oe_n_out = s.xck_oe_n;
endmodule

// [sim/uct_usart_props.sv]
// Checker of bus handshakes and serial line timing for the transmitter
`timescale 1ns/1ns
module uct_usart_props (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Bus channels
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Serial pins
  input wire logic serial_out_pin_out,
  input wire logic serial_out_pin_oe_n_out,
  input wire logic transfer_clock_pin_out,
  input wire logic transfer_clock_pin_oe_n_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // Responses stand until taken
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:2] s_axi_bvalid_out) else $error("write not answered");
  a_ready_busy: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted during response");
  a_err_zero: assert property (s_axi_rvalid_out && s_axi_rresp_out == uct_pkg::RESP_SLVERR |-> s_axi_rdata_out == 32'h0)
    else $error("error read carries data");
  // Serial line ownership and bit timing
  a_start_driven: assert property ($fell(serial_out_pin_out) |-> !serial_out_pin_oe_n_out)
    else $error("start bit while line released");
  a_idle_high: assert property (serial_out_pin_oe_n_out |-> serial_out_pin_out)
    else $error("released line not high");
  a_bit_min: assert property ($changed(serial_out_pin_out) |=> $stable(serial_out_pin_out))
    else $error("bit shorter than two clocks");
  a_clk_driven: assert property ($changed(transfer_clock_pin_out) |-> !transfer_clock_pin_oe_n_out)
    else $error("clock toggles while released");
endmodule
bind uct_usart uct_usart_props u_props (.clk_sys_in, .sys_rst_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .serial_out_pin_out,
  .serial_out_pin_oe_n_out, .transfer_clock_pin_out, .transfer_clock_pin_oe_n_out);

// [sim/uct_peer.sv]
// Remote serial receiver model that captures transmitted frames
`timescale 1ns/1ns
module uct_peer (
  // Clock
  input wire logic clk_sys_in,
  // Line and frame settings
  input wire logic tx_line_in,
  input wire logic [7:0] half_in,
  input wire logic [3:0] len_in,
  // Lines back to the block
  output logic rx_line_out,
  output logic xclk_out,
  // Captured frame and count
  output logic [12:0] frame_out,
  output logic [7:0] count_out
);
  // Receive line rests at pull-up, clock stands still
  initial begin
    rx_line_out = 1'b1;
    xclk_out = 1'b0;
    count_out = 8'h00;
    frame_out = 13'h0000;
  end
  // Sample mid-bit from a start edge, first bit first
  always begin
    @(negedge tx_line_in);
    frame_out = 13'h0000;
    repeat (half_in) @(posedge clk_sys_in);
    for (int i = 0; i < len_in; i++) begin
      frame_out[i] = tx_line_in;
      if (i < len_in - 1) repeat (2 * half_in) @(posedge clk_sys_in);
    end
    count_out <= count_out + 8'h01;
  end
endmodule

// [sim/test_uct_usart.sv]
// Self-checking bench for the serial transmitter block
`timescale 1ns/1ns
module test_uct_usart;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxl, txo, txoe, xin, xout, xoe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] half = 8'h18;
  logic [3:0] len = 4'hA;
  logic [12:0] frame;
  logic [7:0] cnt;
  int errors = 0;
  int comparisons = 0;
  // Clock of 4 ns period
  always #2 clk = ~clk;
  uct_usart u_dut (.clk_sys_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .serial_in_pin_in(rxl),
    .serial_out_pin_out(txo), .serial_out_pin_oe_n_out(txoe), .transfer_clock_pin_in(xin),
    .transfer_clock_pin_out(xout), .transfer_clock_pin_oe_n_out(xoe));
  uct_peer u_peer (.clk_sys_in(clk), .tx_line_in(txo), .half_in(half), .len_in(len), .rx_line_out(rxl),
    .xclk_out(xin), .frame_out(frame), .count_out(cnt));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(input string nm);
    errors++;
    $display("ERROR %s timed out", nm);
    give_verdict;
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw, w;
    int n;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
      n++;
      if (n > 50) hang("write");
    end
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 100) hang("bresp");
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) hang("read");
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 100) hang("rdata");
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_frame(output logic [12:0] f, output int n);
    logic [7:0] c;
    c = cnt;
    n = 0;
    while (cnt === c) begin
      @(posedge clk);
      n++;
      if (n > 3000) hang("frame");
    end
    f = frame;
  endtask
  task automatic wait_done(output logic [31:0] d);
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      rd(uct_pkg::OFS_CSA, d, r);
      n++;
      if (n > 500) hang("done");
    end while (d[6] !== 1'b1);
  endtask
  function automatic logic [12:0] exp_frame(input logic [8:0] d, input int n, input int pm, input int st);
    logic [12:0] f;
    int k;
    f = 13'h1FFF;
    f[0] = 1'b0;
    for (k = 1; k <= n; k++) f[k] = d[k-1];
    if (pm > 1) begin
      f[k] = ^(d & ((9'h001 << n) - 9'h001)) ^ pm[0];
      k++;
    end
    return f & ((13'h0001 << (k + st)) - 13'h0001);
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(uct_pkg::OFS_CSA, d, r);
    chk("csa", d, 32'h20);
    rd(uct_pkg::OFS_CSC, d, r);
    chk("csc", d, {24'h0, uct_pkg::CSC_RST});
    rd(8'h18, d, r);
    chk("unmapped", {d[29:0], r}, {30'h0, uct_pkg::RESP_SLVERR});
    wr(8'h18, 8'hFF, r);
    chk("unmapped wr", r, uct_pkg::RESP_SLVERR);
    wr(uct_pkg::OFS_DIVH, 8'hFF, r);
    rd(uct_pkg::OFS_DIVH, d, r);
    chk("divh", d, 32'h0F);
    wr(uct_pkg::OFS_DIVH, 8'h00, r);
    chk("oe_n off", txoe, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_async;
    logic [12:0] f;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(uct_pkg::OFS_DIVL, 8'h02, r);
    wr(uct_pkg::OFS_CSB, 8'h08, r);
    @(posedge clk);
    chk("oe_n", txoe, 1'b0);
    chk("idle", txo, 1'b1);
    wr(uct_pkg::OFS_DATA, 8'h5A, r);
    n = 0;
    do begin
      rd(uct_pkg::OFS_CSA, d, r);
      n++;
      if (n > 200) hang("empty");
    end while (d[5] !== 1'b1);
    wr(uct_pkg::OFS_DATA, 8'hC3, r);
    rd(uct_pkg::OFS_CSA, d, r);
    chk("flags busy", d[6:5], 2'b00);
    wait_frame(f, n);
    chk("frame1", f, exp_frame(9'h05A, 8, 0, 1));
    wait_frame(f, n);
    chk("frame2", f, exp_frame(9'h0C3, 8, 0, 1));
    chk("period", n, 10 * 3 * 16);
    wait_done(d);
    chk("empty", d[5], 1'b1);
    wr(uct_pkg::OFS_CSA, 8'h40, r);
    rd(uct_pkg::OFS_CSA, d, r);
    chk("done clr", d[6], 1'b0);
    $display("test async done");
  endtask
  task automatic t_formats;
    logic [12:0] f;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] a, b, c;
    logic [8:0] v;
    int n, pm, st, h, m;
    for (int k = 0; k < 3; k++) begin
      case (k)
        0: {a, b, c, h, v, n, pm, st} = {8'h01, 8'h08, 8'h2C, 12, 9'h0D3, 7, 2, 2};
        1: {a, b, c, h, v, n, pm, st} = {8'h00, 8'h08, 8'h30, 24, 9'h0FE, 5, 3, 1};
        default: {a, b, c, h, v, n, pm, st} = {8'h00, 8'h0D, 8'h06, 24, 9'h13C, 9, 0, 1};
      endcase
      wr(uct_pkg::OFS_CSA, a | 8'h40, r);
      wr(uct_pkg::OFS_CSB, b, r);
      wr(uct_pkg::OFS_CSC, c, r);
      half <= h[7:0];
      len <= 4'(1 + n + (pm > 1) + st);
      wr(uct_pkg::OFS_DATA, v[7:0], r);
      wait_frame(f, m);
      chk("format", f, exp_frame(v, n, pm, st));
      wait_done(d);
    end
    $display("test formats done");
  endtask
  task automatic t_sync;
    logic [12:0] f;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    logic x;
    wr(uct_pkg::OFS_CSA, 8'h40, r);
    wr(uct_pkg::OFS_CSB, 8'h08, r);
    wr(uct_pkg::OFS_DIVL, 8'h01, r);
    wr(uct_pkg::OFS_CSC, 8'hC6, r);
    half <= 8'h02;
    len <= 4'hA;
    @(posedge clk);
    chk("xck oe_n", xoe, 1'b0);
    x = xout;
    repeat (2) @(posedge clk);
    chk("xck toggle", xout, !x);
    wr(uct_pkg::OFS_DATA, 8'h96, r);
    wait_frame(f, n);
    chk("sync frame", f, exp_frame(9'h096, 8, 0, 1));
    wait_done(d);
    $display("test sync done");
  endtask
  // Reset, then run every scenario in turn
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_async;
    t_formats;
    t_sync;
    give_verdict;
  end
endmodule
